/* File: gpfm_top.sv */
/*
   Top of the pin function multiplexer: register port, supply code capture,
   registered pin outputs and drive enables. Assumes the register port and all
   source signals are synchronous to clk_i, and that the supply measurement
   input is already a settled 8-bit code.
*/
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE_01 - Read-only 8-bit supply code tracks the measurement; volts equal code over 8.428.
// RULE_02 - Direction bits 2..0 per pin; set means output; all reset cleared.
// RULE_03 - Four-bit selector per pin resets to zero; zero drives pin low.
// RULE_04 - Selector one routes the two-level rail control waveform.
// RULE_05 - Selector two drives the pin from its software output value bit.
// RULE_06 - Selector three outputs mute flag only when both channels are muted.
// RULE_07 - Selectors four and five output left and right mute flags alone.
// RULE_08 - Selector six outputs the clock-invalid flag.
// RULE_09 - Selector eight outputs the active-low warning indication.
// RULE_10 - Selector nine outputs the multi-level rail control waveform.
// RULE_11 - On pins one and two, selector eleven outputs the active-low fault.
// RULE_12 - Selector twelve routes the serial master clock.
// RULE_13 - Selector thirteen routes the serial master data output.
// RULE_14 - Reserved selector codes are not to be used; they drive low here.
// RULE_15 - Per-pin inversion bits 0..2 flip the pin output when set.
// RULE_16 - A pin is driven only while its direction bit marks it output.
module gpfm_top
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic [7:0] supply_measure_code_i,
   input wire logic two_level_i,
   input wire logic multi_level_i,
   input wire logic mute_left_i,
   input wire logic mute_right_i,
   input wire logic clk_invalid_i,
   input wire logic warning_n_i,
   input wire logic fault_n_i,
   input wire logic spi_sck_i,
   input wire logic spi_mosi_i,
   output logic [2:0] pin_out_o,
   output logic [2:0] pin_drive_enable_o
);

   gpfm_cfg_if cfg ();

   gpfm_pkg::gpfm_top_state_t state;
   gpfm_pkg::gpfm_top_state_t next_state;
   gpfm_pkg::gpfm_src_t src;
   logic [2:0] next_pin_out;
   logic [2:0] next_pin_oe;

   assign cfg.wr = reg_wr_i;
   assign cfg.addr = reg_addr_i;
   assign cfg.wdata = reg_wdata_i;

   assign src.two_level = two_level_i;
   assign src.multi_level = multi_level_i;
   assign src.mute_left = mute_left_i;
   assign src.mute_right = mute_right_i;
   assign src.clk_invalid = clk_invalid_i;
   assign src.warning_n = warning_n_i;
   assign src.fault_n = fault_n_i;
   assign src.spi_sck = spi_sck_i;
   assign src.spi_mosi = spi_mosi_i;

   gpfm_regs u_regs
   (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .cfg(cfg.store)
   );

   gpfm_pin_mux u_mux
   (
      .cfg(cfg.route),
      .src_i(src),
      .next_pin_out_o(next_pin_out),
      .next_pin_oe_o(next_pin_oe)
   );

   // Unmapped offsets and reserved upper bits read as zero.
   function automatic logic [7:0] read_value(input logic [7:0] addr, input logic [7:0] supply);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         gpfm_pkg::ADDR_SUPPLY_CODE: v = supply; // RULE_01
         gpfm_pkg::ADDR_PIN_DIR: v = {5'h00, cfg.dir};
         gpfm_pkg::ADDR_PIN0_SEL: v = {4'h0, cfg.sel[0]};
         gpfm_pkg::ADDR_PIN1_SEL: v = {4'h0, cfg.sel[1]};
         gpfm_pkg::ADDR_PIN2_SEL: v = {4'h0, cfg.sel[2]};
         gpfm_pkg::ADDR_PIN_VALUE: v = {5'h00, cfg.value};
         gpfm_pkg::ADDR_PIN_INVERT: v = {5'h00, cfg.invert};
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_value

   always_comb
   begin
      next_state = state;
      // Writes to the supply code are ignored; it always follows the converter.
      next_state.supply = supply_measure_code_i; // RULE_01
      next_state.pin_out = next_pin_out;
      next_state.pin_oe = next_pin_oe; // RULE_16
      next_state.rvalid = reg_rd_i;
      if (reg_rd_i)
         next_state.rdata = read_value(reg_addr_i, state.supply);
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         state <= gpfm_pkg::TOP_RESET; // RULE_01
      else
         state <= next_state;
   end

   assign reg_rdata_o = state.rdata;
   assign reg_rvalid_o = state.rvalid;
   assign pin_out_o = state.pin_out;
   assign pin_drive_enable_o = state.pin_oe;

   // The pin flops add one cycle of latency after the selector stage, which
   // keeps every pin glitch-free at the cost of delaying fast waveforms.

   a_supply_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_01
      !$past(sys_rst_i) ##1 reg_rd_i && reg_addr_i == gpfm_pkg::ADDR_SUPPLY_CODE
      |=> reg_rdata_o == $past(supply_measure_code_i, 2) && reg_rvalid_o)
      else $error("supply code read does not match measurement");

   a_dir_reset: assert property (@(posedge clk_i) // RULE_02
      sys_rst_i |=> cfg.dir == 3'h0 && pin_drive_enable_o == 3'h0)
      else $error("direction not cleared by reset");

   a_dir_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_02
      reg_wr_i && reg_addr_i == gpfm_pkg::ADDR_PIN_DIR |=> cfg.dir == $past(reg_wdata_i[2:0])
      ##1 pin_drive_enable_o == $past(reg_wdata_i[2:0], 2))
      else $error("direction write not reflected on drive enables");

   a_sel_off_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_03
      cfg.sel[0] == gpfm_pkg::SEL_OFF && cfg.dir[0] |=> pin_out_o[0] == $past(cfg.invert[0]))
      else $error("selector off does not drive low");

   a_two_level: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_04
      cfg.sel[1] == gpfm_pkg::SEL_TWO_LEVEL && cfg.dir[1]
      |=> pin_out_o[1] == ($past(two_level_i) ^ $past(cfg.invert[1])))
      else $error("two-level waveform not routed");

   a_reg_value: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_05
      cfg.sel[2] == gpfm_pkg::SEL_REG_VALUE && cfg.dir[2]
      |=> pin_out_o[2] == ($past(cfg.value[2]) ^ $past(cfg.invert[2])))
      else $error("register value not driven");

   a_mute_both: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_06
      cfg.sel[0] == gpfm_pkg::SEL_MUTE_BOTH && cfg.dir[0] && !cfg.invert[0]
      |=> pin_out_o[0] == ($past(mute_left_i) && $past(mute_right_i)))
      else $error("combined mute flag wrong");

   a_mute_left: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_07
      cfg.sel[1] == gpfm_pkg::SEL_MUTE_LEFT && cfg.dir[1] && !cfg.invert[1] |=> pin_out_o[1] == $past(mute_left_i))
      else $error("left mute flag wrong");

   a_mute_right: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_07
      cfg.sel[2] == gpfm_pkg::SEL_MUTE_RIGHT && cfg.dir[2] && !cfg.invert[2] |=> pin_out_o[2] == $past(mute_right_i))
      else $error("right mute flag wrong");

   a_clk_invalid: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_08
      cfg.sel[0] == gpfm_pkg::SEL_CLK_INVALID && cfg.dir[0] && !cfg.invert[0]
      |=> pin_out_o[0] == $past(clk_invalid_i))
      else $error("clock invalid flag wrong");

   a_warning: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_09
      cfg.sel[1] == gpfm_pkg::SEL_WARNING && cfg.dir[1] && !cfg.invert[1] |=> pin_out_o[1] == $past(warning_n_i))
      else $error("warning indication wrong");

   a_multi_level: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_10
      cfg.sel[2] == gpfm_pkg::SEL_MULTI_LEVEL && cfg.dir[2] && !cfg.invert[2]
      |=> pin_out_o[2] == $past(multi_level_i))
      else $error("multi-level waveform wrong");

   a_fault_pin: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_11
      cfg.sel[1] == gpfm_pkg::SEL_FAULT && cfg.dir[1] && !cfg.invert[1] |=> pin_out_o[1] == $past(fault_n_i))
      else $error("fault indication wrong");

   a_spi_clock: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_12
      cfg.sel[0] == gpfm_pkg::SEL_SPI_SCK && cfg.dir[0] && !cfg.invert[0] |=> pin_out_o[0] == $past(spi_sck_i))
      else $error("serial clock not routed");

   a_spi_data: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_13
      cfg.sel[2] == gpfm_pkg::SEL_SPI_MOSI && cfg.dir[2] && !cfg.invert[2] |=> pin_out_o[2] == $past(spi_mosi_i))
      else $error("serial data not routed");

   a_reserved_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_14
      (cfg.sel[0] == gpfm_pkg::SEL_RSVD_7 || cfg.sel[0] == gpfm_pkg::SEL_RSVD_E || cfg.sel[0] == gpfm_pkg::SEL_RSVD_F)
      && !cfg.invert[0] |=> !pin_out_o[0])
      else $error("reserved selector not low");

   a_invert_flip: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_15
      cfg.dir[2] && $stable(cfg.sel[2]) && $stable(cfg.value[2]) && cfg.sel[2] == gpfm_pkg::SEL_REG_VALUE
      && $changed(cfg.invert[2]) |=> $changed(pin_out_o[2]))
      else $error("inversion does not flip output");

   a_drive_off: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_16
      !cfg.dir[1] [*2] |=> !pin_drive_enable_o[1] && !pin_out_o[1])
      else $error("pin driven while input");

   a_supply_reset: assert property (@(posedge clk_i) // RULE_01
      sys_rst_i |=> state.supply == 8'h00 && reg_rdata_o == 8'h00 && !reg_rvalid_o)
      else $error("supply code or read port not cleared by reset");

   // The read answer must not move between reads, or a slow host could latch a torn value.
   a_rdata_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_01
      !reg_rd_i |=> $stable(reg_rdata_o) && !reg_rvalid_o)
      else $error("read data changed without a read");

   c_mute_both: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      cfg.sel[0] == gpfm_pkg::SEL_MUTE_BOTH && cfg.dir[0] ##1 pin_out_o[0]);

   c_spi_route: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      cfg.sel[1] == gpfm_pkg::SEL_SPI_SCK && cfg.sel[2] == gpfm_pkg::SEL_SPI_MOSI && cfg.dir[2:1] == 2'h3);

   c_fault_pin2: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      cfg.sel[2] == gpfm_pkg::SEL_FAULT && cfg.dir[2] ##1 !pin_out_o[2]);

   c_supply_read: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == gpfm_pkg::ADDR_SUPPLY_CODE ##1 reg_rvalid_o && reg_rdata_o != 8'h00);

endmodule : gpfm_top

`default_nettype wire

/* File: gpfm_pkg.sv */
/*
   Constants and types shared by the pin function multiplexer: register offsets,
   field positions, reset values, selector codes and the packed state records.
   Assumes an 8-bit register space reached by a simple strobed register port.
*/
`default_nettype none

package gpfm_pkg;

   localparam int unsigned NUM_PINS = 3;

   // Register byte offsets.
   localparam logic [7:0] ADDR_SUPPLY_CODE = 8'h5E;
   localparam logic [7:0] ADDR_PIN_DIR = 8'h60;
   localparam logic [7:0] ADDR_PIN0_SEL = 8'h61;
   localparam logic [7:0] ADDR_PIN1_SEL = 8'h62;
   localparam logic [7:0] ADDR_PIN2_SEL = 8'h63;
   localparam logic [7:0] ADDR_PIN_VALUE = 8'h65;
   localparam logic [7:0] ADDR_PIN_INVERT = 8'h66;

   // Field layout and reset values.
   localparam int unsigned SEL_LSB = 0;
   localparam int unsigned SEL_WIDTH = 4;
   localparam int unsigned PIN_FIELD_LSB = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] RESET_PIN_BITS = 3'h0;
   localparam logic [3:0] RESET_SEL = 4'h0;

   // Volts are the supply code divided by this figure; kept for software reference.
   localparam real SUPPLY_CODE_PER_VOLT = 8.428;

   // Source selector codes.
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_TWO_LEVEL = 4'h1;
   localparam logic [3:0] SEL_REG_VALUE = 4'h2;
   localparam logic [3:0] SEL_MUTE_BOTH = 4'h3;
   localparam logic [3:0] SEL_MUTE_LEFT = 4'h4;
   localparam logic [3:0] SEL_MUTE_RIGHT = 4'h5;
   localparam logic [3:0] SEL_CLK_INVALID = 4'h6;
   localparam logic [3:0] SEL_RSVD_7 = 4'h7;
   localparam logic [3:0] SEL_WARNING = 4'h8;
   localparam logic [3:0] SEL_MULTI_LEVEL = 4'h9;
   localparam logic [3:0] SEL_FAULT = 4'hB;
   localparam logic [3:0] SEL_SPI_SCK = 4'hC;
   localparam logic [3:0] SEL_SPI_MOSI = 4'hD;
   localparam logic [3:0] SEL_RSVD_E = 4'hE;
   localparam logic [3:0] SEL_RSVD_F = 4'hF;
   localparam int unsigned FAULT_FIRST_PIN = 1;

   typedef struct packed {
      logic two_level;
      logic multi_level;
      logic mute_left;
      logic mute_right;
      logic clk_invalid;
      logic warning_n;
      logic fault_n;
      logic spi_sck;
      logic spi_mosi;
   } gpfm_src_t;

   typedef struct packed {
      logic [2:0] dir;
      logic [2:0][3:0] sel;
      logic [2:0] value;
      logic [2:0] invert;
   } gpfm_regs_state_t;

   localparam gpfm_regs_state_t REGS_RESET = '{dir: RESET_PIN_BITS, sel: {RESET_SEL, RESET_SEL, RESET_SEL},
                                              value: RESET_PIN_BITS, invert: RESET_PIN_BITS};

   typedef struct packed {
      logic [7:0] supply;
      logic [2:0] pin_out;
      logic [2:0] pin_oe;
      logic [7:0] rdata;
      logic rvalid;
   } gpfm_top_state_t;

   localparam gpfm_top_state_t TOP_RESET = '{supply: RESET_BYTE, pin_out: RESET_PIN_BITS,
                                             pin_oe: RESET_PIN_BITS, rdata: RESET_BYTE, rvalid: 1'b0};

endpackage : gpfm_pkg

`default_nettype wire

/* File: gpfm_cfg_if.sv */
/*
   Interface carrying register writes into the configuration store and the
   stored pin configuration out to the read path and the source multiplexer.
   Assumes one clock domain shared by every module that connects to it.
*/
`timescale 1ns/10ps
`default_nettype none

interface gpfm_cfg_if;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [2:0] dir;
   logic [2:0][3:0] sel;
   logic [2:0] value;
   logic [2:0] invert;

   modport store (input wr, input addr, input wdata, output dir, output sel, output value, output invert);
   modport master (output wr, output addr, output wdata, input dir, input sel, input value, input invert);
   modport route (input dir, input sel, input value, input invert);
endinterface : gpfm_cfg_if

`default_nettype wire

/* File: gpfm_regs.sv */
/*
   Writable configuration store: direction, source selectors, output values
   and inversion bits. Assumes writes arrive as single-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none

module gpfm_regs
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   gpfm_cfg_if.store cfg
);

   gpfm_pkg::gpfm_regs_state_t state;
   gpfm_pkg::gpfm_regs_state_t next_state;

   always_comb
   begin
      next_state = state;
      if (cfg.wr)
      begin
         case (cfg.addr)
            gpfm_pkg::ADDR_PIN_DIR: next_state.dir = cfg.wdata[2:0];
            gpfm_pkg::ADDR_PIN0_SEL: next_state.sel[0] = cfg.wdata[3:0];
            gpfm_pkg::ADDR_PIN1_SEL: next_state.sel[1] = cfg.wdata[3:0];
            gpfm_pkg::ADDR_PIN2_SEL: next_state.sel[2] = cfg.wdata[3:0];
            gpfm_pkg::ADDR_PIN_VALUE: next_state.value = cfg.wdata[2:0];
            gpfm_pkg::ADDR_PIN_INVERT: next_state.invert = cfg.wdata[2:0];
            default: next_state = state;
         endcase
      end
   end

   // Every field returns to zero, so all pins come up as undriven inputs.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         state <= gpfm_pkg::REGS_RESET; // RULE_02
      else
         state <= next_state;
   end

   assign cfg.dir = state.dir;
   assign cfg.sel = state.sel;
   assign cfg.value = state.value;
   assign cfg.invert = state.invert;

endmodule : gpfm_regs

`default_nettype wire

/* File: gpfm_pin_mux.sv */
/*
   Combinational source selection for the three pins, before the output flops.
   Assumes the routed source signals are synchronous to the system clock.
*/
`timescale 1ns/10ps
`default_nettype none

module gpfm_pin_mux
(
   gpfm_cfg_if.route cfg,
   input wire gpfm_pkg::gpfm_src_t src_i,
   output logic [2:0] next_pin_out_o,
   output logic [2:0] next_pin_oe_o
);

   function automatic logic route_one(input logic [3:0] sel, input logic value, input int unsigned pin,
                                      input gpfm_pkg::gpfm_src_t src);
      logic r;
      r = 1'b0;
      case (sel)
         gpfm_pkg::SEL_OFF: r = 1'b0; // RULE_03
         gpfm_pkg::SEL_TWO_LEVEL: r = src.two_level; // RULE_04
         gpfm_pkg::SEL_REG_VALUE: r = value; // RULE_05
         gpfm_pkg::SEL_MUTE_BOTH: r = src.mute_left & src.mute_right; // RULE_06
         gpfm_pkg::SEL_MUTE_LEFT: r = src.mute_left; // RULE_07
         gpfm_pkg::SEL_MUTE_RIGHT: r = src.mute_right; // RULE_07
         gpfm_pkg::SEL_CLK_INVALID: r = src.clk_invalid; // RULE_08
         gpfm_pkg::SEL_WARNING: r = src.warning_n; // RULE_09
         gpfm_pkg::SEL_MULTI_LEVEL: r = src.multi_level; // RULE_10
         gpfm_pkg::SEL_FAULT: r = (pin >= gpfm_pkg::FAULT_FIRST_PIN) ? src.fault_n : 1'b0; // RULE_11
         gpfm_pkg::SEL_SPI_SCK: r = src.spi_sck; // RULE_12
         gpfm_pkg::SEL_SPI_MOSI: r = src.spi_mosi; // RULE_13
         // Reserved codes park the source low so a misprogrammed pin is at least quiet.
         default: r = 1'b0; // RULE_14
      endcase
      return r;
   endfunction : route_one

   always_comb
   begin
      next_pin_out_o = 3'h0;
      next_pin_oe_o = 3'h0;
      for (int unsigned i = 0; i < gpfm_pkg::NUM_PINS; i++)
      begin
         next_pin_oe_o[i] = cfg.dir[i]; // RULE_16
         next_pin_out_o[i] = cfg.dir[i] & (route_one(cfg.sel[i], cfg.value[i], i, src_i) ^ cfg.invert[i]); // RULE_15
      end
   end

endmodule : gpfm_pin_mux

`default_nettype wire

/* File: gpfm_src_model.sv */
/*
   Far-side source model: drives the routed waveforms, flags and the supply
   measurement code that the pin multiplexer selects from.
   Assumes the same clock and synchronous reset as the design.
*/
`timescale 1ns/10ps
`default_nettype none

module gpfm_src_model
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic hold_i,
   output var gpfm_pkg::gpfm_src_t src_o,
   output logic [7:0] supply_o
);
   logic [8:0] step;

   // An odd stride keeps every source bit moving within a few cycles, so a wrong route shows quickly.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         step <= 9'h000;
      end
      else if (!hold_i)
      begin
         step <= step + 9'h0B7;
      end
   end

   assign src_o = gpfm_pkg::gpfm_src_t'(step);
   assign supply_o = step[7:0] ^ 8'hA5;
endmodule : gpfm_src_model

`default_nettype wire

/* File: testbench.sv */
/*
   Self-checking bench for the pin function multiplexer: strobed register
   reads and writes, a sweep of every selector code with and without
   inversion on pins 1 and 2, direction gating and the read-only supply code.
   Assumes the source model drives all routed sources.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic hold = 1'b0;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic [7:0] supply;
   logic [2:0] pin_out_o;
   logic [2:0] pin_drive_enable_o;
   gpfm_pkg::gpfm_src_t src;
   int fails = 0;
   int n_compared = 0;
   logic [2:0] m_dir = 3'h0;
   logic [2:0] m_val = 3'h0;
   logic [2:0] m_inv = 3'h0;
   logic [3:0] m_sel [3] = '{4'h0, 4'h0, 4'h0};

   always #10 clk_i = ~clk_i;

   gpfm_src_model gpfm_src_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hold_i(hold), .src_o(src),
                                       .supply_o(supply));

   gpfm_top gpfm_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .supply_measure_code_i(supply), .two_level_i(src.two_level),
      .multi_level_i(src.multi_level), .mute_left_i(src.mute_left), .mute_right_i(src.mute_right),
      .clk_invalid_i(src.clk_invalid), .warning_n_i(src.warning_n), .fault_n_i(src.fault_n),
      .spi_sck_i(src.spi_sck), .spi_mosi_i(src.spi_mosi), .pin_out_o(pin_out_o),
      .pin_drive_enable_o(pin_drive_enable_o));

   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   task check(input string what, input logic [7:0] seen, input logic [7:0] expected);
      n_compared++;
      if (seen !== expected)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, expected, seen);
      end
   endtask : check

   task write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      case (a)
         gpfm_pkg::ADDR_PIN_DIR: m_dir = d[2:0];
         gpfm_pkg::ADDR_PIN0_SEL: m_sel[0] = d[3:0];
         gpfm_pkg::ADDR_PIN1_SEL: m_sel[1] = d[3:0];
         gpfm_pkg::ADDR_PIN2_SEL: m_sel[2] = d[3:0];
         gpfm_pkg::ADDR_PIN_VALUE: m_val = d[2:0];
         gpfm_pkg::ADDR_PIN_INVERT: m_inv = d[2:0];
         default: ;
      endcase
   endtask : write_reg

   // The answer is looked at in the one cycle that reg_rvalid_o stands, right after the taking edge.
   task read_reg(input logic [7:0] a, input logic [7:0] expected);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      check("reg_rvalid", {7'h00, reg_rvalid_o}, 8'h01);
      check("reg_rdata", reg_rdata_o, expected);
   endtask : read_reg

   function automatic logic exp_pin(input int i, input gpfm_pkg::gpfm_src_t s);
      logic r;
      case (m_sel[i])
         4'h0: r = 1'b0;
         4'h1: r = s.two_level;
         4'h2: r = m_val[i];
         4'h3: r = s.mute_left & s.mute_right;
         4'h4: r = s.mute_left;
         4'h5: r = s.mute_right;
         4'h6: r = s.clk_invalid;
         4'h8: r = s.warning_n;
         4'h9: r = s.multi_level;
         4'hB: r = (i >= 1) ? s.fault_n : 1'b0;
         4'hC: r = s.spi_sck;
         4'hD: r = s.spi_mosi;
         default: r = 1'b0;
      endcase
      return m_dir[i] & (r ^ m_inv[i]);
   endfunction : exp_pin

   // Sources sampled at the edge are the ones the design registered at that same edge.
   task check_pins(input int n);
      gpfm_pkg::gpfm_src_t s;
      repeat (n)
      begin
         @(posedge clk_i);
         s = src;
         #1;
         check("pin_out", {5'h00, pin_out_o}, {5'h00, exp_pin(2, s), exp_pin(1, s), exp_pin(0, s)});
         check("pin_drive_enable", {5'h00, pin_drive_enable_o}, {5'h00, m_dir});
      end
   endtask : check_pins

   initial
   begin
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      check_pins(2);
      read_reg(gpfm_pkg::ADDR_PIN_DIR, 8'h00);
      read_reg(gpfm_pkg::ADDR_PIN0_SEL, 8'h00);
      read_reg(gpfm_pkg::ADDR_PIN1_SEL, 8'h00);
      read_reg(gpfm_pkg::ADDR_PIN2_SEL, 8'h00);
      read_reg(gpfm_pkg::ADDR_PIN_INVERT, 8'h00);
      $display("Test reset values done");

      write_reg(gpfm_pkg::ADDR_PIN_DIR, 8'h07);
      write_reg(gpfm_pkg::ADDR_PIN_VALUE, 8'h05);
      for (int inv = 0; inv < 2; inv++)
      begin
         write_reg(gpfm_pkg::ADDR_PIN_INVERT, (inv == 1) ? 8'h06 : 8'h00);
         for (int c = 0; c < 16; c++)
         begin
            for (int p = 0; p < 3; p++)
            begin
               write_reg(gpfm_pkg::ADDR_PIN0_SEL + 8'(p), {4'h0, 4'(c) ^ 4'(p)});
            end
            check_pins(12);
         end
      end
      $display("Test selector sweep done");

      write_reg(gpfm_pkg::ADDR_PIN0_SEL, 8'hF2);
      write_reg(gpfm_pkg::ADDR_PIN_DIR, 8'h02);
      check_pins(8);
      read_reg(gpfm_pkg::ADDR_PIN_DIR, 8'h02);
      read_reg(gpfm_pkg::ADDR_PIN0_SEL, 8'h02);
      write_reg(8'h70, 8'hFF);
      read_reg(8'h70, 8'h00);
      $display("Test direction and reserved bits done");

      write_reg(gpfm_pkg::ADDR_PIN1_SEL, 8'h0C);
      write_reg(gpfm_pkg::ADDR_PIN2_SEL, 8'h0D);
      write_reg(gpfm_pkg::ADDR_PIN_DIR, 8'h06);
      check_pins(4);
      write_reg(gpfm_pkg::ADDR_PIN2_SEL, 8'h02);
      write_reg(gpfm_pkg::ADDR_PIN_INVERT, 8'h00);
      check_pins(2);
      write_reg(gpfm_pkg::ADDR_PIN_INVERT, 8'h04);
      check_pins(2);
      $display("Test serial routes and inversion done");

      @(posedge clk_i);
      hold <= 1'b1;
      repeat (3) @(posedge clk_i);
      read_reg(gpfm_pkg::ADDR_SUPPLY_CODE, supply);
      write_reg(gpfm_pkg::ADDR_SUPPLY_CODE, ~supply);
      read_reg(gpfm_pkg::ADDR_SUPPLY_CODE, supply);
      hold <= 1'b0;
      $display("Test supply code done");
      report_and_stop();
   end

   // The tests need under 2000 cycles; this limit leaves wide margin.
   initial
   begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule : testbench

`default_nettype wire
